// >>> axis_offset_correction.sv
// Notes on behaviour
// [RL1] Trim values are 8-bit two's complement
// [RL2] One trim LSB weighs 2 mg
// [RL3] Trim added to sample before output registers
// [RL4] Trim writes accepted only in standby
// [RL5] X trim register, reset zero
// [RL6] Y trim register, reset zero
// [RL7] Z trim register, reset zero
// [RL8] Trim scaled to range, sum saturates
`timescale 1ns/1ps
`default_nettype none

module axis_offset_correction (
   input  wire logic                                      pclk,
   input  wire logic                                      presetn,
   input  wire logic                                      psel,
   input  wire logic                                      penable,
   input  wire logic                                      pwrite,
   input  wire logic [axis_offset_pkg::ADDR_WIDTH-1:0]    paddr,
   input  wire logic [axis_offset_pkg::DATA_WIDTH-1:0]    pwdata,
   output logic      [axis_offset_pkg::DATA_WIDTH-1:0]    prdata,
   output logic                                           pready,
   output logic                                           pslverr,
   input  wire logic                                      sample_valid,
   input  wire logic [axis_offset_pkg::SAMPLE_WIDTH-1:0]  sample_x,
   input  wire logic [axis_offset_pkg::SAMPLE_WIDTH-1:0]  sample_y,
   input  wire logic [axis_offset_pkg::SAMPLE_WIDTH-1:0]  sample_z,
   output logic                                           active_mode,
   output logic                                           data_ready
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic addr_hit(
      input logic [axis_offset_pkg::ADDR_WIDTH-1:0]  addr,
      input logic [axis_offset_pkg::INDEX_WIDTH-1:0] index
   );
      addr_hit = (addr == {2'b00, index, 2'b00});
   endfunction : addr_hit

   function automatic logic [axis_offset_pkg::SHIFT_WIDTH-1:0] range_shift(
      input logic [1:0] fs
   );
      unique case (axis_offset_pkg::fs_range_type'(fs))
         axis_offset_pkg::FS_2G:       range_shift = axis_offset_pkg::SHIFT_2G;
         axis_offset_pkg::FS_4G:       range_shift = axis_offset_pkg::SHIFT_4G;
         axis_offset_pkg::FS_8G:       range_shift = axis_offset_pkg::SHIFT_8G;
         axis_offset_pkg::FS_RESERVED: range_shift = axis_offset_pkg::SHIFT_8G;
      endcase
   endfunction : range_shift

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [axis_offset_pkg::TRIM_WIDTH-1:0]   trim_reg [axis_offset_pkg::AXIS_COUNT];
   logic [axis_offset_pkg::SAMPLE_WIDTH-1:0] data_reg [axis_offset_pkg::AXIS_COUNT];
   logic [axis_offset_pkg::SAMPLE_WIDTH-1:0] data_next [axis_offset_pkg::AXIS_COUNT];
   logic [axis_offset_pkg::SAMPLE_WIDTH-1:0] sample_in [axis_offset_pkg::AXIS_COUNT];
   logic [axis_offset_pkg::CTRL_USED-1:0]    ctrl_reg;
   logic [axis_offset_pkg::DATA_WIDTH-1:0]   read_value;
   logic [axis_offset_pkg::SHIFT_WIDTH-1:0]  shift_sel;
   logic                                     setup_phase;
   logic                                     access_done;
   logic                                     wr_commit;
   logic                                     addr_error;
   logic                                     write_refused;
   logic                                     trim_hit;
   logic                                     sample_take;

   assign sample_in[0] = sample_x;
   assign sample_in[1] = sample_y;
   assign sample_in[2] = sample_z;
   assign shift_sel    = range_shift(ctrl_reg[axis_offset_pkg::FS_MSB:axis_offset_pkg::FS_LSB]);
   assign setup_phase  = psel && !penable;
   assign access_done  = psel && penable && pready;
   assign wr_commit    = access_done && pwrite && !pslverr;
   assign sample_take  = sample_valid && ctrl_reg[axis_offset_pkg::ACTIVE_BIT];

   // ------------------------------------------------------------
   // Correction per axis
   // ------------------------------------------------------------
   for (genvar a = 0; a < axis_offset_pkg::AXIS_COUNT; a++) begin : g_axis
      axis_trim_adder u_adder (
         .sample    (sample_in[a]),
         .trim      (trim_reg[a]),
         .shift     (shift_sel),
         .corrected (data_next[a])
      );
   end

   // ------------------------------------------------------------
   // Address decode and read mux
   // ------------------------------------------------------------
   always_comb begin
      trim_hit   = addr_hit(paddr, axis_offset_pkg::X_TRIM_INDEX) ||
                   addr_hit(paddr, axis_offset_pkg::Y_TRIM_INDEX) ||
                   addr_hit(paddr, axis_offset_pkg::Z_TRIM_INDEX);
      read_value = '0;
      addr_error = 1'b0;
      if (addr_hit(paddr, axis_offset_pkg::OUT_X_MSB_INDEX)) begin
         read_value[7:0] = data_reg[0][13:6];
      end else if (addr_hit(paddr, axis_offset_pkg::OUT_X_LSB_INDEX)) begin
         read_value[7:0] = {data_reg[0][5:0], 2'b00};
      end else if (addr_hit(paddr, axis_offset_pkg::OUT_Y_MSB_INDEX)) begin
         read_value[7:0] = data_reg[1][13:6];
      end else if (addr_hit(paddr, axis_offset_pkg::OUT_Y_LSB_INDEX)) begin
         read_value[7:0] = {data_reg[1][5:0], 2'b00};
      end else if (addr_hit(paddr, axis_offset_pkg::OUT_Z_MSB_INDEX)) begin
         read_value[7:0] = data_reg[2][13:6];
      end else if (addr_hit(paddr, axis_offset_pkg::OUT_Z_LSB_INDEX)) begin
         read_value[7:0] = {data_reg[2][5:0], 2'b00};
      end else if (addr_hit(paddr, axis_offset_pkg::X_TRIM_INDEX)) begin
         read_value[7:0] = trim_reg[0];
      end else if (addr_hit(paddr, axis_offset_pkg::Y_TRIM_INDEX)) begin
         read_value[7:0] = trim_reg[1];
      end else if (addr_hit(paddr, axis_offset_pkg::Z_TRIM_INDEX)) begin
         read_value[7:0] = trim_reg[2];
      end else if (addr_hit(paddr, axis_offset_pkg::STANDBY_CTRL_INDEX)) begin
         read_value[axis_offset_pkg::CTRL_USED-1:0] = ctrl_reg;
      end else begin
         addr_error = 1'b1;
      end
      // Output data is read only; trims lock while sampling
      write_refused = pwrite && !addr_error && !trim_hit &&
                      !addr_hit(paddr, axis_offset_pkg::STANDBY_CTRL_INDEX);
      if (pwrite && trim_hit && ctrl_reg[axis_offset_pkg::ACTIVE_BIT]) begin
         write_refused = 1'b1;                                               // [RL4]
      end
   end

   // ------------------------------------------------------------
   // APB answer: one wait-free access cycle, all from flops
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else if (setup_phase) begin
         pready  <= 1'b1;
         pslverr <= addr_error || write_refused;
         prdata  <= pwrite ? '0 : read_value;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Standby control
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= axis_offset_pkg::CTRL_RESET;
      end else if (wr_commit && addr_hit(paddr, axis_offset_pkg::STANDBY_CTRL_INDEX)) begin
         ctrl_reg <= pwdata[axis_offset_pkg::CTRL_USED-1:0];
      end
   end

   assign active_mode = ctrl_reg[axis_offset_pkg::ACTIVE_BIT];

   // ------------------------------------------------------------
   // Trim registers
   // ------------------------------------------------------------
   // Refused writes never reach here: pslverr blocks wr_commit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trim_reg[0] <= axis_offset_pkg::TRIM_RESET;                         // [RL5]
         trim_reg[1] <= axis_offset_pkg::TRIM_RESET;                         // [RL6]
         trim_reg[2] <= axis_offset_pkg::TRIM_RESET;                         // [RL7]
      end else if (wr_commit) begin                                          // [RL4]
         if (addr_hit(paddr, axis_offset_pkg::X_TRIM_INDEX)) begin
            trim_reg[0] <= pwdata[axis_offset_pkg::TRIM_WIDTH-1:0];          // [RL5]
         end
         if (addr_hit(paddr, axis_offset_pkg::Y_TRIM_INDEX)) begin
            trim_reg[1] <= pwdata[axis_offset_pkg::TRIM_WIDTH-1:0];          // [RL6]
         end
         if (addr_hit(paddr, axis_offset_pkg::Z_TRIM_INDEX)) begin
            trim_reg[2] <= pwdata[axis_offset_pkg::TRIM_WIDTH-1:0];          // [RL7]
         end
      end
   end

   // ------------------------------------------------------------
   // Output data registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int a = 0; a < axis_offset_pkg::AXIS_COUNT; a++) begin
            data_reg[a] <= axis_offset_pkg::DATA_RESET;
         end
      end else if (sample_take) begin
         for (int a = 0; a < axis_offset_pkg::AXIS_COUNT; a++) begin
            data_reg[a] <= data_next[a];                                     // [RL3]
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_ready <= 1'b0;
      end else begin
         data_ready <= sample_take;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_setup;
      psel && !penable;
   endsequence

   sequence s_access;
      psel && penable && pready;
   endsequence

   a_ready_after_setup: assert property (s_setup |=> pready)
      else $error("pready missing after setup");
   a_ready_one_cycle: assert property (s_access |=> !pready)
      else $error("pready held too long");
   a_trim_locked_active: assert property (                                   // [RL4]
      active_mode |=> ($stable(trim_reg[0]) && $stable(trim_reg[1]) && $stable(trim_reg[2])))
      else $error("trim changed while active");
   a_x_trim_write: assert property (                                         // [RL5]
      s_access ##0 (pwrite && !active_mode && addr_hit(paddr, axis_offset_pkg::X_TRIM_INDEX))
      |=> trim_reg[0] == $past(pwdata[7:0]))
      else $error("x trim write lost");
   a_y_trim_write: assert property (                                         // [RL6]
      s_access ##0 (pwrite && !active_mode && addr_hit(paddr, axis_offset_pkg::Y_TRIM_INDEX))
      |=> trim_reg[1] == $past(pwdata[7:0]))
      else $error("y trim write lost");
   a_z_trim_write: assert property (                                         // [RL7]
      s_access ##0 (pwrite && !active_mode && addr_hit(paddr, axis_offset_pkg::Z_TRIM_INDEX))
      |=> trim_reg[2] == $past(pwdata[7:0]))
      else $error("z trim write lost");
   a_zero_trim_pass: assert property (                                       // [RL3]
      (sample_take && trim_reg[0] == 8'h00) |=> (data_reg[0] == $past(sample_x) && data_ready))
      else $error("sample altered with zero trim");
   a_scale_two_g: assert property (                                          // [RL1] [RL2]
      (sample_take && sample_x == 14'h0000 && ctrl_reg[2:1] == 2'b00)
      |=> data_reg[0] == {{3{$past(trim_reg[0][7])}}, $past(trim_reg[0]), 3'b000})
      else $error("trim scaling wrong at 2g");
   a_sat_high: assert property (                                             // [RL8]
      (sample_take && sample_y == 14'h1FFF && !trim_reg[1][7]) |=> data_reg[1] == 14'h1FFF)
      else $error("no positive saturation");
   a_sat_low: assert property (                                              // [RL8]
      (sample_take && sample_z == 14'h2000 && trim_reg[2][7]) |=> data_reg[2] == 14'h2000)
      else $error("no negative saturation");

endmodule : axis_offset_correction

`default_nettype wire

// >>> axis_offset_correction_bench.sv
`timescale 1ns/1ps
`default_nettype none

module axis_offset_correction_bench;

   // ------------------------------------------------------------
   // Clock, reset and ports
   // ------------------------------------------------------------
   logic                                     pclk = 1'b0;
   logic                                     presetn = 1'b0;
   logic                                     psel = 1'b0;
   logic                                     penable = 1'b0;
   logic                                     pwrite = 1'b0;
   logic [axis_offset_pkg::ADDR_WIDTH-1:0]   paddr = 12'h000;
   logic [axis_offset_pkg::DATA_WIDTH-1:0]   pwdata = 32'h00000000;
   logic [axis_offset_pkg::DATA_WIDTH-1:0]   prdata;
   logic                                     pready;
   logic                                     pslverr;
   logic                                     sample_valid = 1'b0;
   logic [axis_offset_pkg::SAMPLE_WIDTH-1:0] sample_x = 14'h0000;
   logic [axis_offset_pkg::SAMPLE_WIDTH-1:0] sample_y = 14'h0000;
   logic [axis_offset_pkg::SAMPLE_WIDTH-1:0] sample_z = 14'h0000;
   logic                                     active_mode;
   logic                                     data_ready;
   int                                       errors = 0;
   int                                       check_count = 0;

   always #20 pclk = ~pclk;

   axis_offset_correction i_axis_offset_correction (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_valid(sample_valid), .sample_x(sample_x), .sample_y(sample_y),
      .sample_z(sample_z), .active_mode(active_mode), .data_ready(data_ready)
   );

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask : chk

   // Idle cycle first, so no strobe is assigned twice in one step
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {2'h0, idx, 2'h0};
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      chk(n, 32'h00000001, "ready wait");
   endtask : apb

   task automatic wr(input logic [7:0] idx, input logic [31:0] wd, input logic exp_err);
      logic [31:0] d;
      logic        e;
      apb(1'b1, idx, wd, d, e);
      chk({31'h0, e}, {31'h0, exp_err}, "write error flag");
   endtask : wr

   task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic exp_err);
      logic [31:0] d;
      logic        e;
      apb(1'b0, idx, 32'h00000000, d, e);
      chk({31'h0, e}, {31'h0, exp_err}, "read error flag");
      chk(d, exp, "read data");
   endtask : rd

   task automatic set_mode(input logic [1:0] fs, input logic act);
      wr(axis_offset_pkg::STANDBY_CTRL_INDEX, {29'h0, fs, act}, 1'b0);
      #1 chk({31'h0, active_mode}, {31'h0, act}, "active mode");
   endtask : set_mode

   task automatic send(input logic [13:0] x, input logic [13:0] y, input logic [13:0] z,
                       input logic exp_ready);
      @(posedge pclk);
      sample_valid <= 1'b1;
      sample_x     <= x;
      sample_y     <= y;
      sample_z     <= z;
      @(posedge pclk);
      sample_valid <= 1'b0;
      #1 chk({31'h0, data_ready}, {31'h0, exp_ready}, "ready pulse");
      @(posedge pclk);
      #1 chk({31'h0, data_ready}, 32'h00000000, "ready pulse end");
   endtask : send

   // Reference sum, saturated to the 14-bit output word
   function automatic logic [13:0] corr(input logic [13:0] s, input logic [7:0] t, input int sh);
      int v;
      v = $signed(s) + $signed(t) * (2 ** sh);
      if (v > 8191) v = 8191;
      if (v < -8192) v = -8192;
      return v[13:0];
   endfunction : corr

   task automatic check_axis(input int a, input logic [13:0] s, input logic [7:0] t, input int sh);
      logic [13:0] e;
      e = corr(s, t, sh);
      rd(8'(2 * a + 1), {24'h0, e[13:6]}, 1'b0);
      rd(8'(2 * a + 2), {24'h0, e[5:0], 2'h0}, 1'b0);
   endtask : check_axis

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      rd(axis_offset_pkg::X_TRIM_INDEX, 32'h00000000, 1'b0);
      rd(axis_offset_pkg::Y_TRIM_INDEX, 32'h00000000, 1'b0);
      rd(axis_offset_pkg::Z_TRIM_INDEX, 32'h00000000, 1'b0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_standby_ignore;
      send(14'h1234, 14'h0567, 14'h0ABC, 1'b0);
      rd(axis_offset_pkg::OUT_X_MSB_INDEX, 32'h00000000, 1'b0);
      $display("test standby ignore done");
   endtask : t_standby_ignore

   task automatic t_trim_rw;
      wr(axis_offset_pkg::X_TRIM_INDEX, 32'h000000E2, 1'b0);
      wr(axis_offset_pkg::Y_TRIM_INDEX, 32'h0000007F, 1'b0);
      wr(axis_offset_pkg::Z_TRIM_INDEX, 32'h00000080, 1'b0);
      rd(axis_offset_pkg::X_TRIM_INDEX, 32'h000000E2, 1'b0);
      rd(axis_offset_pkg::Y_TRIM_INDEX, 32'h0000007F, 1'b0);
      rd(axis_offset_pkg::Z_TRIM_INDEX, 32'h00000080, 1'b0);
      $display("test trim access done");
   endtask : t_trim_rw

   // Mid and zero sample on X, saturation on Y and Z, every range
   task automatic t_correct;
      int shf [4];
      shf = '{3, 2, 1, 1};
      for (int fs = 0; fs < 4; fs++) begin
         set_mode(2'(fs), 1'b1);
         send(14'h0100, 14'h1FF0, 14'h2005, 1'b1);
         check_axis(0, 14'h0100, 8'hE2, shf[fs]);
         check_axis(1, 14'h1FF0, 8'h7F, shf[fs]);
         check_axis(2, 14'h2005, 8'h80, shf[fs]);
         send(14'h0000, 14'h1FFF, 14'h2000, 1'b1);
         check_axis(0, 14'h0000, 8'hE2, shf[fs]);
         check_axis(1, 14'h1FFF, 8'h7F, shf[fs]);
         check_axis(2, 14'h2000, 8'h80, shf[fs]);
      end
      $display("test correction done");
   endtask : t_correct

   task automatic t_zero_trim;
      set_mode(2'h1, 1'b0);
      wr(axis_offset_pkg::X_TRIM_INDEX, 32'h00000000, 1'b0);
      set_mode(2'h1, 1'b1);
      send(14'h0ABC, 14'h0000, 14'h0000, 1'b1);
      check_axis(0, 14'h0ABC, 8'h00, 2);
      check_axis(1, 14'h0000, 8'h11, 2);
      $display("test zero trim done");
   endtask : t_zero_trim

   task automatic t_active_lock;
      set_mode(2'h0, 1'b1);
      wr(axis_offset_pkg::Y_TRIM_INDEX, 32'h00000011, 1'b1);
      rd(axis_offset_pkg::Y_TRIM_INDEX, 32'h0000007F, 1'b0);
      set_mode(2'h0, 1'b0);
      wr(axis_offset_pkg::Y_TRIM_INDEX, 32'h00000011, 1'b0);
      rd(axis_offset_pkg::Y_TRIM_INDEX, 32'h00000011, 1'b0);
      $display("test active lock done");
   endtask : t_active_lock

   task automatic t_unmapped;
      rd(8'h40, 32'h00000000, 1'b1);
      wr(8'h40, 32'h000000FF, 1'b1);
      wr(axis_offset_pkg::OUT_Z_LSB_INDEX, 32'h000000FF, 1'b1);
      $display("test unmapped done");
   endtask : t_unmapped

   // ------------------------------------------------------------
   // Run control
   // ------------------------------------------------------------
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results

   // Whole run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      results();
   end

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_standby_ignore();
      t_trim_rw();
      t_correct();
      t_active_lock();
      t_zero_trim();
      t_unmapped();
      results();
   end

endmodule : axis_offset_correction_bench

`default_nettype wire

// >>> axis_offset_pkg.sv
package axis_offset_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int AXIS_COUNT   = 3;
   localparam int TRIM_WIDTH   = 8;
   localparam int SAMPLE_WIDTH = 14;
   localparam int SUM_WIDTH    = 16;
   localparam int DATA_WIDTH   = 32;
   localparam int ADDR_WIDTH   = 12;
   localparam int INDEX_WIDTH  = 8;
   localparam int SHIFT_WIDTH  = 2;

   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [INDEX_WIDTH-1:0] OUT_X_MSB_INDEX   = 8'h01;
   localparam logic [INDEX_WIDTH-1:0] OUT_X_LSB_INDEX   = 8'h02;
   localparam logic [INDEX_WIDTH-1:0] OUT_Y_MSB_INDEX   = 8'h03;
   localparam logic [INDEX_WIDTH-1:0] OUT_Y_LSB_INDEX   = 8'h04;
   localparam logic [INDEX_WIDTH-1:0] OUT_Z_MSB_INDEX   = 8'h05;
   localparam logic [INDEX_WIDTH-1:0] OUT_Z_LSB_INDEX   = 8'h06;
   localparam logic [INDEX_WIDTH-1:0] X_TRIM_INDEX      = 8'h2F;
   localparam logic [INDEX_WIDTH-1:0] Y_TRIM_INDEX      = 8'h30;
   localparam logic [INDEX_WIDTH-1:0] Z_TRIM_INDEX      = 8'h31;
   localparam logic [INDEX_WIDTH-1:0] STANDBY_CTRL_INDEX = 8'h5B;

   // ------------------------------------------------------------
   // Standby control fields and reset values
   // ------------------------------------------------------------
   localparam int ACTIVE_BIT = 0;
   localparam int FS_LSB     = 1;
   localparam int FS_MSB     = 2;
   localparam int CTRL_USED  = 3;
   localparam logic [CTRL_USED-1:0]  CTRL_RESET = 3'h0;
   localparam logic [TRIM_WIDTH-1:0] TRIM_RESET = 8'h00;
   localparam logic [SAMPLE_WIDTH-1:0] DATA_RESET = 14'h0000;
   localparam int LSB_PAD = 2;

   // ------------------------------------------------------------
   // Full-scale range and trim scaling
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      FS_2G       = 2'b00,
      FS_4G       = 2'b01,
      FS_8G       = 2'b10,
      FS_RESERVED = 2'b11
   } fs_range_type;

   localparam int TRIM_LSB_MG = 2;
   localparam logic [SHIFT_WIDTH-1:0] SHIFT_2G = 2'h3;
   localparam logic [SHIFT_WIDTH-1:0] SHIFT_4G = 2'h2;
   localparam logic [SHIFT_WIDTH-1:0] SHIFT_8G = 2'h1;

   localparam logic signed [SUM_WIDTH-1:0] SAT_MAX = 16'sh1FFF;
   localparam logic signed [SUM_WIDTH-1:0] SAT_MIN = -16'sh2000;

endpackage : axis_offset_pkg

// >>> axis_trim_adder.sv
`timescale 1ns/1ps
`default_nettype none

module axis_trim_adder (
   input  wire logic [axis_offset_pkg::SAMPLE_WIDTH-1:0] sample,
   input  wire logic [axis_offset_pkg::TRIM_WIDTH-1:0]   trim,
   input  wire logic [axis_offset_pkg::SHIFT_WIDTH-1:0]  shift,
   output logic      [axis_offset_pkg::SAMPLE_WIDTH-1:0] corrected
);

   logic signed [axis_offset_pkg::SUM_WIDTH-1:0] trim_ext;
   logic signed [axis_offset_pkg::SUM_WIDTH-1:0] sample_ext;
   logic signed [axis_offset_pkg::SUM_WIDTH-1:0] sum;

   // ------------------------------------------------------------
   // Sign extend, scale, add, clamp
   // ------------------------------------------------------------
   always_comb begin
      trim_ext   = axis_offset_pkg::SUM_WIDTH'($signed(trim));              // [RL1]
      trim_ext   = trim_ext <<< shift;                                       // [RL2] [RL8]
      sample_ext = axis_offset_pkg::SUM_WIDTH'($signed(sample));
      // No overflow: 16 bits hold 14-bit sample plus 11-bit scaled trim
      sum        = sample_ext + trim_ext;                                    // [RL3]
      if (sum > axis_offset_pkg::SAT_MAX) begin                              // [RL8]
         corrected = axis_offset_pkg::SAT_MAX[axis_offset_pkg::SAMPLE_WIDTH-1:0];
      end else if (sum < axis_offset_pkg::SAT_MIN) begin
         corrected = axis_offset_pkg::SAT_MIN[axis_offset_pkg::SAMPLE_WIDTH-1:0];
      end else begin
         corrected = sum[axis_offset_pkg::SAMPLE_WIDTH-1:0];
      end
   end

endmodule : axis_trim_adder

`default_nettype wire
